// ==== common/insulation_relay_pkg.sv ====
`default_nettype none
package insulation_relay_pkg;
  // register byte offsets
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] ALARM_THR_OFS = 8'h04;
  localparam logic [7:0] WARN_THR_OFS = 8'h08;
  localparam logic [7:0] COMMAND_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
  localparam logic [7:0] MEASURE_OFS = 8'h1c;

  // config field positions
  localparam int CFG_INS_FS = 0;
  localparam int CFG_WARN_LO = 1;
  localparam int CFG_INH_LO = 3;
  localparam int CFG_ACK_INH = 5;
  localparam int CFG_RELAY_ACK = 6;
  localparam int CFG_CORR_EN = 7;
  localparam int CFG_TEST_RELAYS = 8;
  localparam int CFG_W = 9;
  // failsafe, mirror, normally open, inhibit acknowledge on, rest off
  localparam logic [8:0] CFG_RESET = 9'h025;

  // command bits
  localparam int CMD_ACK = 0;

  // status bits
  localparam int ST_INS_ALARM = 0;
  localparam int ST_WARN = 1;
  localparam int ST_INHIBITED = 2;
  localparam int ST_INH_ALARM = 3;
  localparam int ST_INOPERATIVE = 4;
  localparam int ST_ALARM_RELAY = 5;
  localparam int ST_WARN_RELAY = 6;
  localparam int ST_ACKED = 7;
  localparam int ST_CLEAR_PULSE = 8;
  localparam int ST_SAFE_CFG = 9;
  localparam int ST_W = 10;

  // interrupt bits
  localparam int IRQ_INS_ALARM = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_INOPERATIVE = 2;
  localparam int IRQ_INH_ALARM = 3;
  localparam int IRQ_FAULT_CLEARED = 4;
  localparam int IRQ_W = 5;

  localparam int RES_W = 16;
  localparam logic [15:0] ALARM_THR_RESET = 16'h0064;
  localparam logic [15:0] WARN_THR_RESET = 16'h01f4;

  // hysteresis: release at threshold plus one fifth (20 percent)
  localparam int HYST_DIV = 5;

  // timing
  localparam int CLK_HZ = 25000000;
  localparam int CLEAR_PULSE_S = 3;
  localparam int CLEAR_PULSE_CYCLES = CLEAR_PULSE_S * CLK_HZ;

  typedef enum logic [1:0] {
    WARN_STANDARD = 2'b00,
    WARN_FAILSAFE = 2'b01,
    WARN_MIRROR = 2'b10
  } warn_mode_e;

  typedef enum logic [1:0] {
    INH_NORM_OPEN = 2'b00,
    INH_NORM_CLOSED = 2'b01,
    INH_OFF = 2'b10
  } inhibit_mode_e;
endpackage
`default_nettype wire

// ==== logic/hyst_compare.sv ====
`timescale 1ns/10ps
`default_nettype none
module hyst_compare
  import insulation_relay_pkg::*;
#(
  parameter int W = RES_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // measurement
  input wire logic enable,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] threshold,
  // result
  output logic alarm
);
  logic [W:0] releaseLevel;

  assign releaseLevel = {1'b0, threshold} + {1'b0, threshold / W'(HYST_DIV)};

  // set below threshold, release only above threshold plus 20 percent
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm <= 1'b0;
    end else if (enable) begin
      if (value < threshold) begin
        alarm <= 1'b1;
      end else if ({1'b0, value} > releaseLevel) begin
        alarm <= 1'b0;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_below_sets: assert property (enable && value < threshold |=> alarm)
    else $error("alarm not set below threshold");
  chk_hyst_release: assert property (enable && {1'b0, value} > releaseLevel |=> !alarm)
    else $error("alarm not released above hysteresis band");
  chk_hyst_hold: assert property (alarm && {1'b0, value} <= releaseLevel |=> alarm)
    else $error("alarm released inside hysteresis band");
endmodule // hyst_compare
`default_nettype wire

// ==== logic/insulation_alarm_relay.sv ====
`timescale 1ns/10ps
`default_nettype none
// Operation
// - mirror mode drives early warning relay inverted
// - deficiency or no supply leaves both relays off
// - mirror mode signals warning only by lamp/bus
// - inhibit acknowledge raises alarm on active inhibit
// - inhibit input off ignores every level change
// - safe setup is reset default, reported
// - optional 3s signal when fault disappears
// - optional relay toggle during manual self-test
// - optional acknowledge changing relays, else unchanged
// - no alarm at threshold plus 20 percent; an alarm already set holds there and releases only above it
// - alarm and relay at threshold minus 20 percent
// - 20 percent hysteresis on both thresholds
module insulation_alarm_relay
  import insulation_relay_pkg::*;
#(
  parameter int CLEAR_CYCLES = CLEAR_PULSE_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement and product health
  input wire logic [RES_W-1:0] resistance,
  input wire logic productFault,
  input wire logic selfTestRun,
  // injection inhibition contact, high while closed
  input wire logic inhibitLevel,
  // relays, high while energized
  output logic alarmRelay,
  output logic warnRelay,
  // indications
  output logic warnLamp,
  output logic faultClearedSignal,
  output logic irq
);
  logic rstMeta, rstSync;
  logic [CFG_W-1:0] cfgQ;
  logic [RES_W-1:0] thrQ [2];
  logic [IRQ_W-1:0] irqStatusQ, irqStatusD, irqMaskQ, events;
  logic [IRQ_W-1:0] irqMaskD;
  logic [1:0] levelAlarm;
  logic [3:0] prevQ, levels;
  logic [31:0] clearCntQ;
  logic ackQ, wrDone, accWait, inhibited, inhibitAlarm, alarmEff, warnEff;
  logic alarmShown, warnShown, testToggle, alarmRelayD, warnRelayD;
  logic cfgFs, cfgMirror, safeCfg, clearStart;
  warn_mode_e warnMode;
  inhibit_mode_e inhMode;

  function automatic logic addrMapped(input logic [7:0] a);
    return a == CONFIG_OFS || a == ALARM_THR_OFS || a == WARN_THR_OFS ||
      a == COMMAND_OFS || a == STATUS_OFS || a == IRQ_STATUS_OFS ||
      a == IRQ_MASK_OFS || a == MEASURE_OFS;
  endfunction

  // relay level for an active condition under failsafe or standard action
  function automatic logic relayLevel(input logic fs, input logic active);
    return fs ? !active : active;
  endfunction

  // reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  assign warnMode = warn_mode_e'(cfgQ[CFG_WARN_LO +: 2]);
  assign inhMode = inhibit_mode_e'(cfgQ[CFG_INH_LO +: 2]);
  assign cfgFs = cfgQ[CFG_INS_FS];
  assign cfgMirror = warnMode == WARN_MIRROR;

  always_comb begin
    unique case (inhMode)
      INH_NORM_OPEN: inhibited = inhibitLevel;
      INH_NORM_CLOSED: inhibited = !inhibitLevel;
      INH_OFF: inhibited = 1'b0;
      default: inhibited = 1'b0;
    endcase
  end

  assign safeCfg = cfgFs && cfgMirror && (inhMode == INH_NORM_OPEN || inhMode == INH_OFF) &&
    cfgQ[CFG_ACK_INH] && !cfgQ[CFG_RELAY_ACK] && !cfgQ[CFG_CORR_EN] && !cfgQ[CFG_TEST_RELAYS];

  // measurement frozen while injection is inhibited
  generate
    for (genvar i = 0; i < 2; i++) begin : gLevel
      hyst_compare #(.W(RES_W)) uCompare (
        .mclk(mclk),
        .rst_n(rstSync),
        .enable(!inhibited),
        .value(resistance),
        .threshold(thrQ[i]),
        .alarm(levelAlarm[i])
      );
    end
  endgenerate

  assign inhibitAlarm = cfgQ[CFG_ACK_INH] && inhibited;
  assign alarmEff = levelAlarm[0] || inhibitAlarm;
  assign warnEff = levelAlarm[1];
  assign alarmShown = alarmEff && !ackQ;
  assign warnShown = warnEff && !ackQ;
  assign testToggle = selfTestRun && cfgQ[CFG_TEST_RELAYS];

  always_comb begin
    alarmRelayD = !productFault && (relayLevel(cfgFs, alarmShown) ^ testToggle);
    unique case (warnMode)
      WARN_MIRROR: warnRelayD = !productFault && !alarmRelayD;
      WARN_FAILSAFE: warnRelayD = !productFault && (!warnShown ^ testToggle);
      WARN_STANDARD: warnRelayD = !productFault && (warnShown ^ testToggle);
      default: warnRelayD = !productFault && (warnShown ^ testToggle);
    endcase
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      alarmRelay <= 1'b0;
      warnRelay <= 1'b0;
      warnLamp <= 1'b0;
    end else begin
      alarmRelay <= alarmRelayD;
      warnRelay <= warnRelayD;
      warnLamp <= warnEff;
    end
  end

  // apb: one wait state, answer registered
  assign accWait = psel && penable && !pready;
  assign wrDone = psel && penable && pready && pwrite && addrMapped(paddr);

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= accWait;
      pslverr <= accWait && !addrMapped(paddr);
      prdata <= 32'h0000_0000;
      if (accWait && !pwrite) begin
        unique case (paddr)
          CONFIG_OFS: prdata <= 32'(cfgQ);
          ALARM_THR_OFS: prdata <= 32'(thrQ[0]);
          WARN_THR_OFS: prdata <= 32'(thrQ[1]);
          STATUS_OFS: prdata <= 32'({safeCfg, faultClearedSignal, ackQ, warnRelay, alarmRelay,
            productFault, inhibitAlarm, inhibited, warnEff, levelAlarm[0]});
          IRQ_STATUS_OFS: prdata <= 32'(irqStatusQ);
          IRQ_MASK_OFS: prdata <= 32'(irqMaskQ);
          MEASURE_OFS: prdata <= 32'(resistance);
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      cfgQ <= CFG_RESET;
      thrQ[0] <= ALARM_THR_RESET;
      thrQ[1] <= WARN_THR_RESET;
      irqMaskQ <= '0;
    end else if (wrDone) begin
      if (paddr == CONFIG_OFS) begin
        cfgQ <= pwdata[CFG_W-1:0];
      end
      if (paddr == ALARM_THR_OFS) begin
        thrQ[0] <= pwdata[RES_W-1:0];
      end
      if (paddr == WARN_THR_OFS) begin
        thrQ[1] <= pwdata[RES_W-1:0];
      end
      if (paddr == IRQ_MASK_OFS) begin
        irqMaskQ <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // acknowledge holds relays at normal only while the option is on
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      ackQ <= 1'b0;
    end else if (!cfgQ[CFG_RELAY_ACK] || !(alarmEff || warnEff)) begin
      ackQ <= 1'b0;
    end else if (wrDone && paddr == COMMAND_OFS && pwdata[CMD_ACK]) begin
      ackQ <= 1'b1;
    end
  end

  // 3 s signal after an insulation fault disappears
  assign clearStart = prevQ[0] && !levelAlarm[0];

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      faultClearedSignal <= 1'b0;
      clearCntQ <= 32'h0000_0000;
    end else if (!cfgQ[CFG_CORR_EN]) begin
      faultClearedSignal <= 1'b0;
      clearCntQ <= 32'h0000_0000;
    end else if (clearStart) begin
      faultClearedSignal <= 1'b1;
      clearCntQ <= 32'(CLEAR_CYCLES - 1);
    end else if (faultClearedSignal) begin
      if (clearCntQ == 32'h0000_0000) begin
        faultClearedSignal <= 1'b0;
      end else begin
        clearCntQ <= clearCntQ - 32'h0000_0001;
      end
    end
  end

  // interrupts: sticky, write one to clear, a new event wins
  assign levels = {inhibitAlarm, productFault, warnEff, levelAlarm[0]};
  assign events = {clearStart, levels & ~prevQ};
  // a mask write reaches irq at the same edge as the new mask
  assign irqMaskD = (wrDone && paddr == IRQ_MASK_OFS) ? pwdata[IRQ_W-1:0] : irqMaskQ;

  always_comb begin
    irqStatusD = irqStatusQ;
    if (wrDone && paddr == IRQ_STATUS_OFS) begin
      irqStatusD = irqStatusD & ~pwdata[IRQ_W-1:0];
    end
    irqStatusD = irqStatusD | events;
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      prevQ <= '0;
      irqStatusQ <= '0;
      irq <= 1'b0;
    end else begin
      prevQ <= levels;
      irqStatusQ <= irqStatusD;
      irq <= |(irqStatusD & irqMaskD);
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstSync);

  sequence sClearStart;
    cfgQ[CFG_CORR_EN] && clearStart;
  endsequence
  sequence sPulseOn;
    faultClearedSignal [*2];
  endsequence

  chk_mirror_inverse: assert property (cfgMirror && !productFault |=> warnRelay != alarmRelay)
    else $error("mirror relay not inverse of alarm relay");
  chk_fault_deenergize: assert property (productFault |=> !alarmRelay && !warnRelay)
    else $error("relays energized during product deficiency");
  chk_mirror_no_warn: assert property (cfgMirror && !productFault && alarmRelayD |=> !warnRelay)
    else $error("warning drove mirrored relay");
  chk_inhibit_alarm: assert property (cfgQ[CFG_ACK_INH] && inhibited && cfgFs && !productFault && !testToggle
    && !ackQ |=> !alarmRelay)
    else $error("inhibition did not raise alarm");
  chk_inhibit_off: assert property (inhMode == INH_OFF |-> !inhibited && !inhibitAlarm)
    else $error("inhibit input not ignored when off");
  chk_clear_pulse: assert property (sClearStart and (CLEAR_CYCLES > 2) |=> sPulseOn)
    else $error("fault cleared signal too short");
  chk_clear_disabled: assert property (!cfgQ[CFG_CORR_EN] |=> !faultClearedSignal)
    else $error("fault cleared signal while disabled");
  chk_test_toggle: assert property (selfTestRun && !cfgQ[CFG_TEST_RELAYS] && !productFault && cfgFs
    && !alarmShown |=> alarmRelay)
    else $error("self-test moved relays while option off");
  chk_ack_ignored: assert property (!cfgQ[CFG_RELAY_ACK] |=> !ackQ)
    else $error("acknowledge changed relays while option off");
  chk_failsafe_idle: assert property (cfgFs && !alarmEff && !productFault && !testToggle |=> alarmRelay)
    else $error("failsafe alarm relay not energized");
  chk_irq_level: assert property (|(irqStatusQ & irqMaskQ) |-> irq)
    else $error("interrupt low with unmasked status");
  chk_irq_quiet: assert property (!(|(irqStatusQ & irqMaskQ)) |-> !irq)
    else $error("interrupt high without unmasked status");
  chk_warn_lamp: assert property (warnEff |=> warnLamp)
    else $error("warning lamp off during warning");
  chk_sticky_set: assert property (events[IRQ_INS_ALARM] |=> irqStatusQ[IRQ_INS_ALARM])
    else $error("alarm event lost against clear");

  sequence sAccessWait;
    psel && penable && !pready;
  endsequence
  chk_apb_one_wait: assert property (sAccessWait |=> pready)
    else $error("access not answered after one wait state");
endmodule // insulation_alarm_relay
`default_nettype wire

// ==== verification/plc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module plc_model (
  // relay contacts, high while closed
  input wire logic alarmContact,
  input wire logic warnContact,
  // inhibit request from the bench
  input wire logic inhibitCmd,
  // inhibition line and decoded product state
  output logic inhibitLevel,
  output logic [1:0] plcState
);
  // one digital output drives the line, two digital inputs read the contacts
  always_comb begin
    inhibitLevel = inhibitCmd;
  end

  // 0 healthy, 1 insulation alarm, 2 inoperative, 3 status input issue
  always_comb begin
    if (alarmContact == warnContact) begin
      plcState = 2'h2;
    end else if (inhibitLevel) begin
      plcState = alarmContact ? 2'h3 : 2'h0;
    end else begin
      plcState = alarmContact ? 2'h0 : 2'h1;
    end
  end
endmodule // plc_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import insulation_relay_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err;
  logic [15:0] resistance = 16'h0300;
  logic productFault = 1'b0;
  logic selfTestRun = 1'b0;
  logic inhibitCmd = 1'b0;
  logic inhibitLevel, alarmRelay, warnRelay, warnLamp, faultClearedSignal, irq;
  logic [1:0] plcState;
  int error_cnt = 0;
  int checked = 0;
  int n, k, cnt;

  always #20 mclk = ~mclk;

  insulation_alarm_relay #(.CLEAR_CYCLES(8)) i_insulation_alarm_relay (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resistance(resistance), .productFault(productFault),
    .selfTestRun(selfTestRun), .inhibitLevel(inhibitLevel), .alarmRelay(alarmRelay),
    .warnRelay(warnRelay), .warnLamp(warnLamp), .faultClearedSignal(faultClearedSignal), .irq(irq));

  plc_model i_plc_model (.alarmContact(alarmRelay), .warnContact(warnRelay), .inhibitCmd(inhibitCmd),
    .inhibitLevel(inhibitLevel), .plcState(plcState));

  // failsafe alarm relay with mirrored early warning relay
  function automatic logic [31:0] expRelays(input logic alarm);
    return alarm ? 32'h1 : 32'h2;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // relays follow the measured state two edges later
  task setr(input logic [15:0] r, input logic alarm);
    resistance <= r;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), expRelays(alarm));
  endtask

  initial begin
    void'($urandom(81));
    cyc(12);
    rst_n <= 1'b1;
    cyc(4);
    apb(1'b0, CONFIG_OFS, 32'h0);
    chk(rd, 32'(CFG_RESET));
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(rd[ST_SAFE_CFG]), 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, IRQ_MASK_OFS, 32'h1);
    for (n = 0; n < 6; n++) begin
      setr(16'd601 + 16'($urandom % 1000), 1'b0);
      chk(32'(plcState), 32'h0);
      setr(16'd100 + 16'($urandom % 400), 1'b0);
      chk(32'(warnLamp), 32'h1);
      setr(n == 0 ? 16'd80 : 16'($urandom % 100), 1'b1);
      chk(32'(plcState), 32'h1);
      chk(32'(irq), 32'h1);
      apb(1'b1, IRQ_STATUS_OFS, 32'h1);
      cyc(2);
      chk(32'(irq), 32'h0);
      setr(16'd100 + 16'($urandom % 21), 1'b1);
    end
    apb(1'b1, COMMAND_OFS, 32'h1);
    selfTestRun <= 1'b1;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), expRelays(1'b1));
    selfTestRun <= 1'b0;
    apb(1'b1, CONFIG_OFS, 32'(CFG_RESET) | 32'h80);
    resistance <= 16'd700;
    cnt = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge mclk);
      if (faultClearedSignal === 1'b1) cnt++;
    end
    chk(32'(cnt), 32'h8);
    apb(1'b1, CONFIG_OFS, 32'(CFG_RESET));
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    setr(16'd50, 1'b1);
    chk(32'(irq), 32'h0);
    apb(1'b0, IRQ_STATUS_OFS, 32'h0);
    chk(32'(rd[IRQ_INS_ALARM]), 32'h1);
    setr(16'd900, 1'b0);
    productFault <= 1'b1;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), 32'h0);
    chk(32'(plcState), 32'h2);
    productFault <= 1'b0;
    inhibitCmd <= 1'b1;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), expRelays(1'b1));
    chk(32'(plcState), 32'h0);
    inhibitCmd <= 1'b0;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), expRelays(1'b0));
    apb(1'b1, CONFIG_OFS, 32'(CFG_RESET) | 32'h10);
    inhibitCmd <= 1'b1;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), expRelays(1'b0));
    chk(32'(plcState), 32'h3);
    inhibitCmd <= 1'b0;
    selfTestRun <= 1'b1;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), expRelays(1'b0));
    apb(1'b1, CONFIG_OFS, 32'(CFG_RESET) | 32'h100);
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), expRelays(1'b1));
    selfTestRun <= 1'b0;
    apb(1'b1, CONFIG_OFS, 32'(CFG_RESET) | 32'h40);
    setr(16'd60, 1'b1);
    apb(1'b1, COMMAND_OFS, 32'h1);
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), expRelays(1'b0));
    // standard early warning relay, normally closed inhibit contact
    apb(1'b1, CONFIG_OFS, 32'h0000_0009);
    inhibitCmd <= 1'b1;
    resistance <= 16'd300;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), 32'h3);
    inhibitCmd <= 1'b0;
    resistance <= 16'd900;
    cyc(4);
    chk(32'({alarmRelay, warnRelay}), 32'h3);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
